// ==== core/rsbia_map.svh ====
// Register offsets, field positions and cycle counts for the memory self-test access block.
// What this block does
// - Command register write triggers an internal indirect access; reads return in result.
// - Command bit 27 is one while an indirect write is being processed.
// - Command bit 26 is one when the latest indirect write failed.
// - Command bit 25 latches any write failure until software writes one.
// - Command bit 24 chooses read (0) or write (1) access.
// - Command bits 23:16 pick configuration, command control or status register.
// - Command bits 15:8 carry write data; bits 7:0 pick memory 0 to 21.
// - Result bit 9 is one while an indirect read is in progress.
// - Result bit 8 is one when the indirect read failed.
// - Result bits 7:0 return the byte read from the wrapper register.
// - Configuration bit 3 disables and powers down the selected memory.
// - A rising run bit restarts the test; the bit clears itself when done.
// - Status bit 3 shows memory ready; while low, normal accesses are ignored.
// - Status bit 1 shows pass, valid only while the finished bit is one.
// - Status bit 0 is zero before or during a test, one after it.
`ifndef RSBIA_MAP_SVH
`define RSBIA_MAP_SVH
`define RSBIA_CMD_OFS        8'h00
`define RSBIA_RES_OFS        8'h01
`define RSBIA_CMD_WPEND_BIT  27
`define RSBIA_CMD_WERR_BIT   26
`define RSBIA_CMD_STK_BIT    25
`define RSBIA_CMD_TYPE_BIT   24
`define RSBIA_RES_RPEND_BIT  9
`define RSBIA_RES_RERR_BIT   8
`define RSBIA_WRAP_CFG       8'h00
`define RSBIA_WRAP_CTRL      8'h01
`define RSBIA_WRAP_STAT      8'h02
`define RSBIA_CFG_DISABLE    3
`define RSBIA_CFG_FRC_RDY    2
`define RSBIA_CFG_FRC_NRDY   1
`define RSBIA_CTRL_RUN       0
`define RSBIA_MOD_COUNT      22
`define RSBIA_MOD_LAST       8'h15
`define RSBIA_ACCESS_CYCLES  3'h4
`define RSBIA_BIST_CYCLES    7'h40
`endif

// ==== core/rsbia_pkg.sv ====
// Types shared by the memory self-test access block.
package rsbia_pkg;
   typedef enum logic [1:0] {RSBIA_IDLE, RSBIA_WRITE, RSBIA_READ} rsbia_fsm_t;

   typedef struct packed {
      rsbia_fsm_t  fsm;
      logic [2:0]  cnt;
      logic        acc_type;
      logic [7:0]  acc_addr;
      logic [7:0]  acc_data;
      logic [7:0]  acc_mod;
      logic        wr_err;
      logic        write_failure_latched;
      logic        rd_err;
      logic [7:0]  rd_data;
      logic [31:0] rdata;
   } rsbia_top_t;

   typedef struct packed {
      logic [4:0] cfg;
      logic [2:0] ctrl;
      logic [6:0] count;
      logic       done;
      logic       ok;
   } rsbia_wrap_t;
endpackage : rsbia_pkg

// ==== core/rsbia_wrapper.sv ====
// Per-memory wrapper control: configuration, test command and test status.
`timescale 1ns/1ps
`include "rsbia_map.svh"
module rsbia_wrapper
   import rsbia_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   // Indirect register access
   input  wire logic       wr_en_in,
   input  wire logic [7:0] reg_sel_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] rdata_out,
   // Memory side
   input  wire logic       fault_in,
   output logic            mem_enable_out,
   output logic            mem_ready_out
);
   rsbia_wrap_t st;
   rsbia_wrap_t next_st;
   logic        start;

   assign start = wr_en_in && (reg_sel_in == `RSBIA_WRAP_CTRL)
                  && wdata_in[`RSBIA_CTRL_RUN] && !st.ctrl[`RSBIA_CTRL_RUN];

   always_comb begin
      next_st = st;
      if (wr_en_in && reg_sel_in == `RSBIA_WRAP_CFG) begin
         next_st.cfg = wdata_in[4:0];
      end
      if (wr_en_in && reg_sel_in == `RSBIA_WRAP_CTRL) begin
         next_st.ctrl = wdata_in[2:0];
      end
      if (start) begin
         next_st.count = 7'h00;
         next_st.done  = 1'b0;
         next_st.ok    = 1'b1;
      end else if (st.ctrl[`RSBIA_CTRL_RUN]) begin
         if (fault_in) begin
            next_st.ok = 1'b0;
         end
         next_st.count = st.count + 7'h01;
         if (st.count == `RSBIA_BIST_CYCLES - 7'h01) begin
            next_st.ctrl[`RSBIA_CTRL_RUN] = 1'b0;
            next_st.done                  = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Forcing wins over the engine so software can keep a memory shown ready during test.
   always_comb begin
      if (st.cfg[`RSBIA_CFG_FRC_RDY]) begin
         mem_ready_out = 1'b1;
      end else if (st.cfg[`RSBIA_CFG_FRC_NRDY]) begin
         mem_ready_out = 1'b0;
      end else begin
         mem_ready_out = !st.ctrl[`RSBIA_CTRL_RUN] && !st.cfg[`RSBIA_CFG_DISABLE];
      end
   end

   assign mem_enable_out = !st.cfg[`RSBIA_CFG_DISABLE];

   always_comb begin
      case (reg_sel_in)
         `RSBIA_WRAP_CFG:  rdata_out = {3'h0, st.cfg};
         `RSBIA_WRAP_CTRL: rdata_out = {5'h0, st.ctrl};
         `RSBIA_WRAP_STAT: rdata_out = {4'h0, mem_ready_out, 1'b0, st.ok, st.done};
         default:          rdata_out = 8'h00;
      endcase
   end

   bist_run_len_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      start |=> st.ctrl[0] ##63 (st.ctrl[0] && !st.done) ##1 (!st.ctrl[0] && st.done))
      else $error("Self-test run did not end after the set count.");

   run_not_ready_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (st.ctrl[0] && !st.cfg[2]) |-> !mem_ready_out)
      else $error("Memory shown ready while self-test runs.");
endmodule : rsbia_wrapper

// ==== core/rsbia_top.sv ====
// Direct command and result registers driving indirect access to the memory wrappers.
`timescale 1ns/1ps
`include "rsbia_map.svh"
module rsbia_top
   import rsbia_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        sys_rst_in,
   // Direct register port
   input  wire logic [7:0]                  reg_addr_in,
   input  wire logic                        reg_wr_in,
   input  wire logic                        reg_rd_in,
   input  wire logic [31:0]                 reg_wdata_in,
   output logic      [31:0]                 reg_rdata_out,
   // Preconditions from the rest of the chip
   input  wire logic                        mem_resets_released_in,
   input  wire logic                        link_setup_clear_in,
   // Memory side, one bit per memory module
   input  wire logic [`RSBIA_MOD_COUNT-1:0] mem_fault_in,
   output logic      [`RSBIA_MOD_COUNT-1:0] mem_enable_out,
   output logic      [`RSBIA_MOD_COUNT-1:0] mem_ready_out
);
   rsbia_top_t  st;
   rsbia_top_t  next_st;
   logic        access_allowed;
   logic        cmd_write;
   logic        start_write;
   logic        start_read;
   logic        access_last;
   logic        acc_fail;
   logic        wr_strobe;
   logic        wr_fail_evt;
   logic        rd_done_evt;
   logic        stk_clear;
   logic [7:0]  sel_rdata;
   logic [31:0] cmd_word;
   logic [31:0] res_word;
   logic [7:0]  wrap_rdata [`RSBIA_MOD_COUNT];

   // True when the indirect target exists and allows the access kind.
   function automatic logic target_ok(input logic [7:0] mod,
                                      input logic [7:0] addr,
                                      input logic       is_write);
      logic ok;
      ok = (mod <= `RSBIA_MOD_LAST);
      if (addr > `RSBIA_WRAP_STAT) begin
         ok = 1'b0;
      end
      if (is_write && addr == `RSBIA_WRAP_STAT) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : target_ok

   // Decode of a memory module number against a wrapper slot.
   function automatic logic mod_hit(input logic [7:0] mod, input int slot);
      return mod == 8'(slot);
   endfunction : mod_hit

   // Without released memory resets and quiet link clocks the engine cannot run safely.
   assign access_allowed = mem_resets_released_in && link_setup_clear_in;

   assign cmd_write   = reg_wr_in && (reg_addr_in == `RSBIA_CMD_OFS);
   assign start_write = cmd_write && access_allowed && (st.fsm == RSBIA_IDLE)
                        && reg_wdata_in[`RSBIA_CMD_TYPE_BIT];
   assign start_read  = cmd_write && access_allowed && (st.fsm == RSBIA_IDLE)
                        && !reg_wdata_in[`RSBIA_CMD_TYPE_BIT];
   assign stk_clear   = cmd_write && reg_wdata_in[`RSBIA_CMD_STK_BIT];

   assign access_last = (st.cnt == `RSBIA_ACCESS_CYCLES - 3'h1);
   assign acc_fail    = !target_ok(st.acc_mod, st.acc_addr, st.acc_type);
   assign wr_strobe   = (st.fsm == RSBIA_WRITE) && access_last && !acc_fail;
   assign wr_fail_evt = (st.fsm == RSBIA_WRITE) && access_last && acc_fail;
   assign rd_done_evt = (st.fsm == RSBIA_READ) && access_last;

   always_comb begin
      sel_rdata = 8'h00;
      for (int i = 0; i < `RSBIA_MOD_COUNT; i++) begin
         if (mod_hit(st.acc_mod, i)) begin
            sel_rdata = wrap_rdata[i];
         end
      end
   end

   assign cmd_word = {4'h0, (st.fsm == RSBIA_WRITE), st.wr_err, st.write_failure_latched,
                      st.acc_type, st.acc_addr, st.acc_data, st.acc_mod};
   assign res_word = {22'h0, (st.fsm == RSBIA_READ), st.rd_err, st.rd_data};

   always_comb begin
      next_st = st;
      case (st.fsm)
         RSBIA_IDLE: begin
            next_st.cnt = 3'h0;
            if (start_write || start_read) begin
               next_st.acc_type = reg_wdata_in[`RSBIA_CMD_TYPE_BIT];
               next_st.acc_addr = reg_wdata_in[23:16];
               next_st.acc_data = reg_wdata_in[15:8];
               next_st.acc_mod  = reg_wdata_in[7:0];
               next_st.fsm      = start_write ? RSBIA_WRITE : RSBIA_READ;
            end
         end
         RSBIA_WRITE: begin
            next_st.cnt = st.cnt + 3'h1;
            if (access_last) begin
               next_st.wr_err = acc_fail;
               next_st.fsm    = RSBIA_IDLE;
            end
         end
         RSBIA_READ: begin
            next_st.cnt = st.cnt + 3'h1;
            if (access_last) begin
               next_st.rd_err  = acc_fail;
               next_st.rd_data = acc_fail ? 8'h00 : sel_rdata;
               next_st.fsm     = RSBIA_IDLE;
            end
         end
         default: begin
            next_st.fsm = RSBIA_IDLE;
         end
      endcase
      // A failure landing in the same cycle as a clear keeps the flag set.
      next_st.write_failure_latched = (st.write_failure_latched && !stk_clear) || wr_fail_evt;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `RSBIA_CMD_OFS: next_st.rdata = cmd_word;
            `RSBIA_RES_OFS: next_st.rdata = res_word;
            default:        next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_out = st.rdata;

   // Each memory module gets its own wrapper; only the addressed one sees the write.
   generate
      for (genvar g = 0; g < `RSBIA_MOD_COUNT; g++) begin : g_wrap
         rsbia_wrapper u_wrap (
            .clk_in         (clk_in),
            .sys_rst_in     (sys_rst_in),
            .wr_en_in       (wr_strobe && mod_hit(st.acc_mod, g)),
            .reg_sel_in     (st.acc_addr),
            .wdata_in       (st.acc_data),
            .rdata_out      (wrap_rdata[g]),
            .fault_in       (mem_fault_in[g]),
            .mem_enable_out (mem_enable_out[g]),
            .mem_ready_out  (mem_ready_out[g])
         );
      end
   endgenerate

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   wr_pending_span_a: assert property (
      start_write |=> cmd_word[27] [*4] ##1 !cmd_word[27])
      else $error("Write pending bit did not span the access.");

   rd_pending_span_a: assert property (
      start_read |=> res_word[9] [*4] ##1 !res_word[9])
      else $error("Read pending bit did not span the access.");

   wr_error_flag_a: assert property (
      (st.fsm == RSBIA_WRITE && access_last) |=> (cmd_word[26] == $past(acc_fail)))
      else $error("Write error bit does not match the last write.");

   sticky_set_a: assert property (
      wr_fail_evt |=> cmd_word[25])
      else $error("Write failure did not set the sticky bit.");

   sticky_hold_a: assert property (
      (cmd_word[25] && !stk_clear) |=> cmd_word[25])
      else $error("Sticky bit dropped without a software clear.");

   access_type_a: assert property (
      (start_read || start_write) |=> (st.fsm == ($past(reg_wdata_in[24]) ?
                                                  RSBIA_WRITE : RSBIA_READ)))
      else $error("Access type did not select the matching access.");

   read_data_a: assert property (
      (rd_done_evt && !acc_fail) |=> (res_word[7:0] == $past(sel_rdata) && !res_word[8]))
      else $error("Read result does not hold the wrapper byte.");

   read_fail_a: assert property (
      (start_read && reg_wdata_in[7:0] > 8'h15) |=> ##4 res_word[8])
      else $error("Read of a missing module did not report failure.");

   gated_access_a: assert property (
      (cmd_write && !access_allowed && st.fsm == RSBIA_IDLE) |=> st.fsm == RSBIA_IDLE)
      else $error("Access started while preconditions were not met.");
endmodule : rsbia_top

// ==== sim/rsbia_top_test.sv ====
// Self-checking bench for the memory self-test access block.
`timescale 1ns/1ps
`include "rsbia_map.svh"
module rsbia_top_test;
   import rsbia_pkg::*;
   logic                        clk_in;
   logic                        sys_rst_in;
   logic [7:0]                  reg_addr_in;
   logic                        reg_wr_in;
   logic                        reg_rd_in;
   logic [31:0]                 reg_wdata_in;
   logic [31:0]                 reg_rdata_out;
   logic                        mem_resets_released_in;
   logic                        link_setup_clear_in;
   logic [`RSBIA_MOD_COUNT-1:0] mem_fault_in;
   logic [`RSBIA_MOD_COUNT-1:0] mem_enable_out;
   logic [`RSBIA_MOD_COUNT-1:0] mem_ready_out;
   int                          error_cnt;
   int                          num_checks;
   logic [31:0]                 seed;
   logic [31:0]                 rv;
   logic [7:0]                  m;
   logic [7:0]                  d;

   rsbia_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .mem_resets_released_in(mem_resets_released_in),
      .link_setup_clear_in(link_setup_clear_in), .mem_fault_in(mem_fault_in),
      .mem_enable_out(mem_enable_out), .mem_ready_out(mem_ready_out));

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic end_sim;
      $display("errors %0d checks %0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : check

   function automatic logic [31:0] exp_cmd(input logic wp, input logic we, input logic st,
                                           input logic ty, input logic [7:0] a,
                                           input logic [7:0] dt, input logic [7:0] md);
      return {4'h0, wp, we, st, ty, a, dt, md};
   endfunction : exp_cmd

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] w);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = w;
      reg_wr_in = 1'b1;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] r);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      r = reg_rdata_out;
   endtask : reg_rd

   // Polling is bounded so a stuck pending bit ends the run instead of hanging it.
   task automatic wait_clear(input logic [7:0] a, input int b, output logic [31:0] r);
      for (int k = 0; k < 50; k++) begin
         reg_rd(a, r);
         if (r[b] === 1'b0) return;
      end
      error_cnt++;
      $display("mismatch at %0t: pending bit never cleared", $time);
      end_sim();
   endtask : wait_clear

   task automatic ind_wr(input logic [7:0] a, input logic [7:0] dt, input logic [7:0] md,
                         output logic [31:0] r);
      reg_wr(`RSBIA_CMD_OFS, exp_cmd(1'b0, 1'b0, 1'b0, 1'b1, a, dt, md));
      reg_rd(`RSBIA_CMD_OFS, r);
      check({31'h0, r[`RSBIA_CMD_WPEND_BIT]}, 32'h1, "write pending");
      wait_clear(`RSBIA_CMD_OFS, `RSBIA_CMD_WPEND_BIT, r);
   endtask : ind_wr

   task automatic ind_rd(input logic [7:0] a, input logic [7:0] md, output logic [31:0] r);
      reg_wr(`RSBIA_CMD_OFS, exp_cmd(1'b0, 1'b0, 1'b0, 1'b0, a, 8'h00, md));
      reg_rd(`RSBIA_RES_OFS, r);
      check({31'h0, r[`RSBIA_RES_RPEND_BIT]}, 32'h1, "read pending");
      wait_clear(`RSBIA_RES_OFS, `RSBIA_RES_RPEND_BIT, r);
   endtask : ind_rd

   initial begin
      repeat (100000) @(posedge clk_in);
      error_cnt++;
      $display("mismatch at %0t: run limit reached", $time);
      end_sim();
   end

   initial begin
      seed = 32'h074a49b5;
      error_cnt = 0;
      num_checks = 0;
      sys_rst_in = 1'b1;
      reg_addr_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_wdata_in = 32'h0;
      mem_resets_released_in = 1'b1;
      link_setup_clear_in = 1'b1;
      mem_fault_in = '0;
      repeat (8) @(negedge clk_in);
      sys_rst_in = 1'b0;
      reg_rd(`RSBIA_CMD_OFS, rv);
      check(rv, 32'h0, "command after reset");
      reg_rd(8'h05, rv);
      check(rv, 32'h0, "unmapped read");
      check({10'h0, mem_enable_out}, 32'h003F_FFFF, "enables after reset");
      for (int i = 0; i < 6; i++) begin
         rv = $random(seed);
         m = (i == 0) ? 8'h00 : (i == 1) ? `RSBIA_MOD_LAST : 8'(rv[7:0] % 22);
         d = {3'h0, rv[9:8], 3'h0};
         ind_wr(`RSBIA_WRAP_CFG, d, m, rv);
         check(rv, exp_cmd(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, d, m), "command word");
         check({31'h0, mem_enable_out[m]}, {31'h0, ~d[3]}, "memory enable");
         ind_rd(`RSBIA_WRAP_CFG, m, rv);
         check(rv, {24'h0, d}, "config readback");
         ind_wr(`RSBIA_WRAP_CFG, 8'h00, m, rv);
      end
      ind_wr(`RSBIA_WRAP_CFG, 8'h04, m, rv);
      check({31'h0, mem_ready_out[m]}, 32'h1, "forced ready");
      ind_wr(`RSBIA_WRAP_CFG, 8'h02, m, rv);
      check({31'h0, mem_ready_out[m]}, 32'h0, "forced not ready");
      for (int f = 0; f < 2; f++) begin
         mem_fault_in = (f == 1) ? (22'h1 << m) : 22'h0;
         ind_wr(`RSBIA_WRAP_CTRL, 8'h01, m, rv);
         ind_rd(`RSBIA_WRAP_STAT, m, rv);
         // The pass bit carries no meaning until done is set, so it is masked here.
         check(rv & 32'hFFFF_FFFD, 32'h0, "status while running");
         for (int k = 0; k < 30; k++) begin
            ind_rd(`RSBIA_WRAP_CTRL, m, rv);
            if (rv[0] === 1'b0) break;
         end
         check(rv, 32'h0, "run bit cleared");
         ind_rd(`RSBIA_WRAP_STAT, m, rv);
         check(rv, {30'h0, f == 0, 1'b1}, "status after test");
      end
      mem_fault_in = '0;
      ind_wr(`RSBIA_WRAP_CFG, 8'h00, m, rv);
      check({31'h0, mem_ready_out[m]}, 32'h1, "ready after test");
      ind_wr(`RSBIA_WRAP_STAT, 8'h55, m, rv);
      check(rv, exp_cmd(1'b0, 1'b1, 1'b1, 1'b1, 8'h02, 8'h55, m), "status write");
      d = 8'd22 + 8'($unsigned($random(seed)) % 234);
      ind_wr(`RSBIA_WRAP_CFG, 8'h00, d, rv);
      check(rv, exp_cmd(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00, d), "bad module");
      // A clear that lands in the cycle of a failing write must leave the sticky bit set.
      reg_wr(`RSBIA_CMD_OFS, exp_cmd(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, d));
      repeat (2) @(negedge clk_in);
      reg_wr(`RSBIA_CMD_OFS, exp_cmd(1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00, m));
      reg_rd(`RSBIA_CMD_OFS, rv);
      check(rv, exp_cmd(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00, d), "sticky set wins");
      ind_wr(`RSBIA_WRAP_CFG, 8'h00, m, rv);
      check(rv, exp_cmd(1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00, m), "sticky held");
      ind_rd(`RSBIA_WRAP_CFG, d, rv);
      check(rv, 32'h0000_0100, "bad module read");
      ind_rd(8'h03, m, rv);
      check(rv, 32'h0000_0100, "bad read");
      link_setup_clear_in = 1'b0;
      reg_wr(`RSBIA_CMD_OFS, exp_cmd(1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 8'h08, m));
      repeat (`RSBIA_ACCESS_CYCLES + 2) @(negedge clk_in);
      reg_rd(`RSBIA_CMD_OFS, rv);
      check(rv, exp_cmd(1'b0, 1'b0, 1'b0, 1'b0, 8'h03, 8'h00, m), "refused write");
      check({31'h0, mem_enable_out[m]}, 32'h1, "link not ready");
      link_setup_clear_in = 1'b1;
      mem_resets_released_in = 1'b0;
      reg_wr(`RSBIA_CMD_OFS, exp_cmd(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h08, m));
      repeat (`RSBIA_ACCESS_CYCLES + 2) @(negedge clk_in);
      check({31'h0, mem_enable_out[m]}, 32'h1, "resets held");
      mem_resets_released_in = 1'b1;
      // A second reset while the block is idle must clear the command and result registers and show every memory ready.
      sys_rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      sys_rst_in = 1'b0;
      reg_rd(`RSBIA_CMD_OFS, rv);
      check(rv, 32'h0, "command after second reset");
      reg_rd(`RSBIA_RES_OFS, rv);
      check(rv, 32'h0, "result after second reset");
      check({10'h0, mem_ready_out}, 32'h003F_FFFF, "ready after second reset");
      end_sim();
   end
endmodule : rsbia_top_test
